// [logic/escs_supervisor.sv]
// Purpose: Engine speed command supervisor with APB registers
// Assumes: APB slave, zero wait states, pclk at 10 MHz
// Notes:   Network frames are written into RX by software
//
// Overview of operation
// - Check switches and inputs before acting
// - Supervision veto ignores request, sets inhibit
// - Ignore switches on failure detected
// - Update engine parameters within 38 ms
// - Superseded when active and throttle held lower
// - Superseded false otherwise, never for higher
// - Immediate disengage ends control, sets inhibit
// - Unsupported build sends superseded false
// - Integrity field: valid, invalid, failure
// - Failure detected disengages both functions
// - Inhibit bit: 0 allows, 1 inhibits
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module escs_supervisor
    import escs_pkg::*;
#(
    parameter int UPDATE_CYCLES = ESCS_UPDATE_CYCLES
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link status
    input wire logic comm_ok,
    // Network outputs
    output logic inhibit_req,
    output logic superseded,
    // Engine control parameters
    output logic speed_inc_param,
    output logic speed_dec_param
);
    // Refuse a limit that the update timer cannot serve
    if (UPDATE_CYCLES < 2)
    begin : g_bad_limit
        $error("escs_supervisor: UPDATE_CYCLES too small");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] ctrl_reg;
    logic [3:0] rx_reg;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic inc_q;
    logic dec_q;
    logic fail_q;
    logic late;
    logic supported;
    logic sup_ok;
    logic ovr_low;
    logic ovr_dis;
    logic active;
    logic inhibit_next;

    assign addr_ok = (paddr == ESCS_OFF_CTRL) || (paddr == ESCS_OFF_RX) ||
                     (paddr == ESCS_OFF_STATUS) || (paddr == ESCS_OFF_PARAM);
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= ESCS_CTRL_RESET[4:0];
        else if (wr_en && paddr == ESCS_OFF_CTRL)
            ctrl_reg <= pwdata[4:0];
    end

    // Received switch frame; integrity arrives with the switches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_reg <= {ESCS_INTEG_INVALID, 2'b00};
        else if (wr_en && paddr == ESCS_OFF_RX)
            rx_reg <= pwdata[3:0];
    end

    assign supported = ctrl_reg[ESCS_CTRL_SUPPORT_BIT];
    assign sup_ok = ctrl_reg[ESCS_CTRL_SUP_OK_BIT];
    assign ovr_low = ctrl_reg[ESCS_CTRL_OVR_LOW_BIT];
    assign ovr_dis = ctrl_reg[ESCS_CTRL_OVR_DIS_BIT];
    assign active = ctrl_reg[ESCS_CTRL_ACTIVE_BIT];

    // ------------------------------------------------------------
    // Switch path
    // ------------------------------------------------------------
    escs_switch_filter u_filter
    (
        .pclk(pclk),
        .presetn(presetn),
        .rx_inc(rx_reg[ESCS_RX_INC_BIT]),
        .rx_dec(rx_reg[ESCS_RX_DEC_BIT]),
        .rx_integ(rx_reg[ESCS_RX_INTEG_LSB +: 2]),
        .comm_ok(comm_ok),
        .inc_q(inc_q),
        .dec_q(dec_q),
        .fail_q(fail_q)
    );

    escs_update_timer #(.LIMIT_CYCLES(UPDATE_CYCLES)) u_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .inc_q(inc_q),
        .dec_q(dec_q),
        .inc_param(speed_inc_param),
        .dec_param(speed_dec_param),
        .late(late)
    );

    // ------------------------------------------------------------
    // Supervision
    // ------------------------------------------------------------
    // Inhibit whenever supervision vetoes, an override forces
    // disengagement, or switch data failed; unsupported builds too.
    always_comb
    begin
        inhibit_next = 1'b0;
        if (!supported)
            inhibit_next = 1'b1;
        if (!sup_ok)
            inhibit_next = 1'b1;
        if (ovr_dis)
            inhibit_next = 1'b1;
        if (fail_q)
            inhibit_next = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            inhibit_req <= 1'b0;
        else
            inhibit_req <= inhibit_next;
    end

    // Superseded only for a lower override while engaged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            superseded <= 1'b0;
        else
            superseded <= supported && active && !inhibit_next &&
                          ovr_low;
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en && !penable)
        begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                ESCS_OFF_CTRL:
                    prdata[4:0] <= ctrl_reg;
                ESCS_OFF_RX:
                    prdata[3:0] <= rx_reg;
                ESCS_OFF_STATUS:
                    prdata[5:0] <= {fail_q, comm_ok, dec_q, inc_q,
                                    superseded, inhibit_req};
                ESCS_OFF_PARAM:
                    prdata[2:0] <= {late, speed_dec_param, speed_inc_param};
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // escs_supervisor
`default_nettype wire

// [logic/escs_switch_filter.sv]
// Purpose: Qualifies received speed switch bits
// Assumes: Inputs synchronous to pclk
// Notes:   Failed integrity or lost link forces both switches false
`timescale 1ns/10ps
`default_nettype none
module escs_switch_filter
    import escs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Received frame content
    input wire logic rx_inc,
    input wire logic rx_dec,
    input wire logic [1:0] rx_integ,
    input wire logic comm_ok,
    // Qualified switches
    output logic inc_q,
    output logic dec_q,
    output logic fail_q
);
    logic fail;
    assign fail = (rx_integ == ESCS_INTEG_FAILURE);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inc_q <= 1'b0;
            dec_q <= 1'b0;
        end
        else if (fail || !comm_ok)
        begin
            inc_q <= 1'b0;
            dec_q <= 1'b0;
        end
        else
        begin
            inc_q <= rx_inc;
            dec_q <= rx_dec;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fail_q <= 1'b0;
        else
            fail_q <= fail && comm_ok;
    end
endmodule // escs_switch_filter
`default_nettype wire

// [logic/escs_update_timer.sv]
// Purpose: Bounds the delay from switch change to parameter update
// Assumes: One clock, pclk
// Notes:   Update is taken well inside the limit, on the next cycle
`timescale 1ns/10ps
`default_nettype none
module escs_update_timer
    import escs_pkg::*;
#(
    parameter int LIMIT_CYCLES = ESCS_UPDATE_CYCLES
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Qualified switches
    input wire logic inc_q,
    input wire logic dec_q,
    // Engine control parameters
    output logic inc_param,
    output logic dec_param,
    output logic late
);
    // Refuse a limit that the age counter cannot time
    if (LIMIT_CYCLES < 2)
    begin : g_bad_limit
        $error("escs_update_timer: LIMIT_CYCLES too small");
    end

    logic [31:0] age_reg;
    logic pending;
    assign pending = (inc_q != inc_param) || (dec_q != dec_param);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inc_param <= 1'b0;
            dec_param <= 1'b0;
        end
        else
        begin
            inc_param <= inc_q;
            dec_param <= dec_q;
        end
    end

    // Watchdog on the update path; flags a missed deadline
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            age_reg <= 32'h0000_0000;
            late <= 1'b0;
        end
        else
        begin
            age_reg <= pending ? age_reg + 32'h0000_0001 : 32'h0000_0000;
            late <= late || (age_reg >= 32'(LIMIT_CYCLES));
        end
    end
endmodule // escs_update_timer
`default_nettype wire

// [pkg/escs_pkg.sv]
// Purpose: Shared constants for the engine speed command supervisor
// Assumes: APB with 32-bit data, pclk at 10 MHz
// Notes:   Offsets are byte addresses of aligned words
package escs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ESCS_OFF_CTRL = 8'h00;
    localparam logic [7:0] ESCS_OFF_RX = 8'h04;
    localparam logic [7:0] ESCS_OFF_STATUS = 8'h08;
    localparam logic [7:0] ESCS_OFF_PARAM = 8'h0C;
    // CTRL fields
    localparam int ESCS_CTRL_SUPPORT_BIT = 0;
    localparam int ESCS_CTRL_SUP_OK_BIT = 1;
    localparam int ESCS_CTRL_OVR_LOW_BIT = 2;
    localparam int ESCS_CTRL_OVR_DIS_BIT = 3;
    localparam int ESCS_CTRL_ACTIVE_BIT = 4;
    localparam logic [31:0] ESCS_CTRL_RESET = 32'h0000_0003;
    // RX / STATUS / PARAM fields
    localparam int ESCS_RX_INC_BIT = 0;
    localparam int ESCS_RX_DEC_BIT = 1;
    localparam int ESCS_RX_INTEG_LSB = 2;
    localparam int ESCS_ST_INHIBIT_BIT = 0;
    localparam int ESCS_ST_SUPERSEDED_BIT = 1;
    localparam int ESCS_ST_INC_BIT = 2;
    localparam int ESCS_ST_DEC_BIT = 3;
    localparam int ESCS_ST_COMM_BIT = 4;
    localparam int ESCS_ST_FAIL_BIT = 5;
    localparam int ESCS_PARAM_INC_BIT = 0;
    localparam int ESCS_PARAM_DEC_BIT = 1;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int ESCS_CLK_HZ = 10_000_000;
    localparam int ESCS_UPDATE_MS = 38;
    localparam int ESCS_UPDATE_CYCLES = ESCS_UPDATE_MS * (ESCS_CLK_HZ / 1000);
    // ------------------------------------------------------------
    // Switch data integrity encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ESCS_INTEG_VALID = 2'h0,
        ESCS_INTEG_INVALID = 2'h1,
        ESCS_INTEG_FAILURE = 2'h2
    } escs_integ_t;
endpackage

// [verification/escs_platform_model.sv]
// Purpose: Platform switch module on the far side of the supervisor
// Assumes: Switch inputs arrive already debounced
// Notes:   Frame word is laid out as the RX register
`timescale 1ns/10ps
`default_nettype none
module escs_platform_model
#(
    parameter int HOLD_CYCLES = 4
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Platform build and switches
    input wire logic fitted,
    input wire logic power_take_off_supported,
    input wire logic on_sw,
    input wire logic inc_sw,
    input wire logic dec_sw,
    input wire logic [1:0] integ,
    // Flag from the supervisor
    input wire logic superseded,
    // Network side
    output logic comm_ok,
    output logic [31:0] frame,
    // Platform reaction to the superseded flag
    output logic give_up,
    output logic learn_hold
);
    logic [31:0] f;
    logic on_ok;
    logic [3:0] held;
    // On-switch reported false unless integrity is valid
    assign on_ok = on_sw && (integ == 2'h0);
    // Inputs are taken as debounced booleans
    // Build without power take-off support: increase and decrease switches forced false
    // Integrity goes in the same frame as the switches
    assign f = {27'h0, on_ok, integ, dec_sw & power_take_off_supported,
                inc_sw & power_take_off_supported};
    // Calibratable hold of the superseded flag before giving up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            held <= 4'h0;
        else if (!superseded)
            held <= 4'h0;
        else if (held != 4'hF)
            held <= held + 4'h1;
    end
    assign give_up = superseded && (held >= 4'(HOLD_CYCLES));
    // Learning pauses while the throttle is held down
    assign learn_hold = superseded;
    // Absent module sends nothing, so the link is lost
    assign comm_ok = fitted;
    // A silent sender leaves no stale word behind
    assign frame = fitted ? f : ~f;
endmodule // escs_platform_model
`default_nettype wire

// [verification/escs_supervisor_bench.sv]
// Purpose: Self-checking bench of the speed command supervisor
// Assumes: Reads checked by a monitor against queued notes
// Notes:   UPDATE_CYCLES shortened to 8
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module escs_supervisor_bench
    import escs_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wire logic comm_ok;
    logic inhibit_req;
    logic superseded;
    logic speed_inc_param;
    logic speed_dec_param;
    logic fitted = 1'b1;
    logic power_take_off_ok = 1'b1;
    logic give_up;
    logic learn_hold;
    logic inc_sw = 1'b0;
    logic dec_sw = 1'b0;
    logic [1:0] integ = 2'h0;
    logic [31:0] frame;
    logic [4:0] ctrl = 5'h03;
    logic [4:0] tbl [6] = '{5'h17, 5'h13, 5'h1F, 5'h16, 5'h15, 5'h07};
    logic [32:0] expq [$];
    logic [32:0] e;
    int err_count = 0;
    int compares = 0;
    always #50 pclk = ~pclk;
    escs_platform_model far (.pclk(pclk), .presetn(presetn),
        .fitted(fitted), .power_take_off_supported(power_take_off_ok),
        .on_sw(1'b1), .inc_sw(inc_sw), .dec_sw(dec_sw), .integ(integ),
        .superseded(superseded), .comm_ok(comm_ok), .frame(frame),
        .give_up(give_up), .learn_hold(learn_hold));
    escs_supervisor #(.UPDATE_CYCLES(8)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comm_ok(comm_ok), .inhibit_req(inhibit_req),
        .superseded(superseded), .speed_inc_param(speed_inc_param),
        .speed_dec_param(speed_dec_param));
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        expq.push_back(x);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic send(input logic i, input logic d, input logic [1:0] g);
        #10;
        inc_sw = i;
        dec_sw = d;
        integ = g;
        #10;
        apb(1'b1, ESCS_OFF_RX, frame);
    endtask
    task automatic settle_check;
        logic fail;
        logic inh;
        logic sup;
        logic [1:0] sw;
        repeat (4) @(posedge pclk);
        fail = integ == ESCS_INTEG_FAILURE;
        inh = !ctrl[0] || !ctrl[1] || ctrl[3] || fail;
        sup = ctrl[0] & ctrl[4] & ctrl[2] & !inh;
        sw = frame[1:0] & {2{comm_ok & !fail}};
        rd(ESCS_OFF_STATUS, {27'h0, fail, comm_ok, sw, sup, inh});
        rd(ESCS_OFF_PARAM, {31'h0, sw});
        `CHK(give_up, sup)
        `CHK(learn_hold, sup)
    endtask
    task automatic end_sim;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Read completions are matched to the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
        begin
            e = expq.pop_front();
            `CHK({pslverr, prdata}, e)
        end
    end
    initial
    begin
        #(3000 * 100);
        err_count++;
        $display("watchdog expired");
        end_sim();
    end
    initial
    begin
        void'($urandom(87265));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(ESCS_OFF_CTRL, {1'b0, ESCS_CTRL_RESET});
        rd(ESCS_OFF_RX, 33'h0_0000_0004);
        settle_check();
        for (int i = 0; i < 12; i++)
        begin
            power_take_off_ok = i < 9;
            send(1'($urandom), 1'($urandom), 2'(i % 3));
            settle_check();
        end
        send(1'b1, 1'b1, 2'h0);
        @(posedge pclk);
        fitted <= 1'b0;
        settle_check();
        @(posedge pclk);
        fitted <= 1'b1;
        power_take_off_ok <= 1'b1;
        send(1'b1, 1'b0, 2'h0);
        settle_check();
        foreach (tbl[k])
        begin
            ctrl = tbl[k];
            apb(1'b1, ESCS_OFF_CTRL, {27'h0, ctrl});
            rd(ESCS_OFF_CTRL, {28'h0, ctrl});
            settle_check();
        end
        ctrl = 5'h17;
        apb(1'b1, ESCS_OFF_CTRL, {27'h0, ctrl});
        send(1'b1, 1'b1, 2'h2);
        settle_check();
        apb(1'b1, ESCS_OFF_STATUS, 32'hFFFF_FFFF);
        settle_check();
        apb(1'b1, 8'h10, 32'h1234_5678);
        rd(8'h10, {1'b1, 32'h0});
        end_sim();
    end
endmodule // escs_supervisor_bench
bind escs_supervisor escs_supervisor_checker #(.UPDATE_CYCLES(UPDATE_CYCLES))
    chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comm_ok(comm_ok),
    .inhibit_req(inhibit_req), .superseded(superseded),
    .speed_inc_param(speed_inc_param), .speed_dec_param(speed_dec_param));
`default_nettype wire

// [verification/escs_supervisor_checker.sv]
// Purpose: Port checks of the speed command supervisor
// Assumes: Bound to escs_supervisor
// Notes:   Windows cover the three-stage switch path
`timescale 1ns/10ps
`default_nettype none
module escs_supervisor_checker
    import escs_pkg::*;
#(
    parameter int UPDATE_CYCLES = ESCS_UPDATE_CYCLES
)
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Link and outputs
    input wire logic comm_ok,
    input wire logic inhibit_req,
    input wire logic superseded,
    input wire logic speed_inc_param,
    input wire logic speed_dec_param
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic wc;
    logic wx;
    assign wr = psel && penable && pwrite;
    assign wc = wr && paddr == ESCS_OFF_CTRL;
    assign wx = wr && paddr == ESCS_OFF_RX;
    a_super_allow: assert property (superseded |-> !inhibit_req)
        else $error("superseded while inhibited");
    a_super_set: assert property (wc && pwdata[4:0] == 5'h17 ##1
        (!wc && !wx)[*2] ##0 !inhibit_req |-> superseded)
        else $error("superseded not set");
    a_not_higher: assert property (wc && !pwdata[2] ##1 (!wc)[*2]
        |-> !superseded)
        else $error("superseded without lower override");
    a_veto_inhibit: assert property (wc && !pwdata[1] ##1 (!wc)[*2]
        |-> inhibit_req)
        else $error("veto did not inhibit");
    a_override_stop: assert property (wc && pwdata[3] ##1 (!wc)[*2]
        |-> inhibit_req && !superseded)
        else $error("override did not disengage");
    a_unsupported_quiet: assert property (wc && !pwdata[0] ##1 (!wc)[*2]
        |-> inhibit_req && !superseded)
        else $error("unsupported build output wrong");
    a_fail_ignore: assert property (wx && pwdata[3:2] == 2'h2 ##1 (!wx)[*3]
        |-> inhibit_req && !speed_inc_param && !speed_dec_param)
        else $error("failure not handled");
    a_update_bound: assert property (wx && pwdata[0] && pwdata[3:2] == 2'h0
        && comm_ok ##1 (!wx && comm_ok)[*3] |-> speed_inc_param)
        else $error("increase parameter late");
    a_dec_clear: assert property (wx && !pwdata[1] ##1 (!wx)[*3]
        |-> !speed_dec_param)
        else $error("decrease parameter stuck");
    a_comm_lost: assert property ((!comm_ok)[*3]
        |-> !speed_inc_param && !speed_dec_param)
        else $error("switches kept on lost link");
endmodule // escs_supervisor_checker
`default_nettype wire
